// ===== card_power_map.svh
`ifndef CARD_POWER_MAP_SVH
`define CARD_POWER_MAP_SVH

// Clock rate and power-up timing
`define CLK_MHZ 32'h0000_0064
`define READY_TIME_US 32'h0000_03e8
`define PREP_BUS_CLOCKS 7'h4a

// Synchroniser lane positions
`define SYN_MAIN 0
`define SYN_LOW 1
`define SYN_LOWEST 2
`define SYN_BUS_CLK 3
`define SYN_CMD 4
`define SYN_CS_N 5
`define SYN_WIDTH 6

// Reset values
`define SYN_RESET 6'h00
`define CLK_CNT_RESET 7'h00

`endif

// ===== card_power_pkg.sv
`default_nettype none
package card_power_pkg;
   typedef enum logic [1:0] {
      ST_OFF,
      ST_PREP,
      ST_IDLE
   } card_state_t;
endpackage : card_power_pkg
`default_nettype wire

// ===== card_power_up_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "card_power_map.svh"

// Behaviour
// - Serial bus card accepts its first command within 1 ms of supply good.
// - Card may use up to 74 bus clocks preparing before first command.
// - After any power-up, including hot insertion, card starts idle.
// - Lane card ready for PHY init within 1 ms of later supply.
// - Lowest-voltage supply replaces the 1.8 V supply, never both together.
// - Power-off notification disables queuing, cache and self-maintenance.
// - Reset command with chip select low selects SPI, else stay silent native.
module card_power_up_sequencer #(
   parameter int READY_CYCLES = `READY_TIME_US * `CLK_MHZ
) (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   // Supply detectors, asynchronous
   input wire logic i_main_supply_ok,
   input wire logic i_low_voltage_supply_ok,
   input wire logic i_lowest_voltage_supply_ok,
   // Serial bus pins, asynchronous
   input wire logic i_bus_clk,
   input wire logic i_cmd_line,
   input wire logic i_cs_n,
   // Configuration from card logic
   input wire logic i_lane_mode,
   input wire logic i_lowest_supported,
   // Command and enhancement events from card logic
   input wire logic i_cmd0_rx,
   input wire logic i_enable_cmd_queuing,
   input wire logic i_enable_cache,
   input wire logic i_enable_self_maint,
   input wire logic i_power_off_notify,
   // Sequencer state
   output card_power_pkg::card_state_t o_state,
   output logic o_idle,
   output logic o_ready_for_cmd,
   output logic o_phy_init_ready,
   // Bus mode
   output logic o_spi_mode,
   output logic o_cmd0_respond,
   // Supply selection
   output logic o_use_lowest_supply,
   output logic o_supply_conflict,
   // Performance enhancements
   output logic o_cmd_queuing_en,
   output logic o_cache_en,
   output logic o_self_maint_en
);
   import card_power_pkg::*;

   localparam int TW = $clog2(READY_CYCLES + 1);

   typedef struct packed {
      card_state_t state;
      logic [TW-1:0] timer;
      logic [6:0] clk_cnt;
      logic [`SYN_WIDTH-1:0] s1;
      logic [`SYN_WIDTH-1:0] s2;
      logic [`SYN_WIDTH-1:0] s3;
      logic [`SYN_WIDTH-1:0] filt;
      logic ready;
      logic phy_ready;
      logic spi;
      logic respond;
      logic use_lowest;
      logic conflict;
      logic cq;
      logic cache;
      logic maint;
   } seq_t;

   seq_t st_r;
   seq_t st_nxt;
   logic [`SYN_WIDTH-1:0] agree;
   logic [`SYN_WIDTH-1:0] pins;
   logic supply_good;
   logic bus_clk_rise;
   logic timer_done;

   assign pins = {i_cs_n, i_cmd_line, i_bus_clk, i_lowest_voltage_supply_ok, i_low_voltage_supply_ok,
                  i_main_supply_ok};
   // Later stages agree before a change counts
   assign agree = st_r.s2 ^~ st_r.s3;
   assign supply_good = st_r.filt[`SYN_MAIN] &
                        (!i_lane_mode | st_r.filt[`SYN_LOW] | st_r.filt[`SYN_LOWEST]);
   assign bus_clk_rise = agree[`SYN_BUS_CLK] & st_r.s2[`SYN_BUS_CLK] & !st_r.filt[`SYN_BUS_CLK];
   assign timer_done = (st_r.timer == TW'(READY_CYCLES - 1));

   always_comb begin
      st_nxt = st_r;
      // Three-flop synchroniser on every pin
      st_nxt.s1 = pins;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // Filtered level moves once stages agree
      st_nxt.filt = (st_r.filt & ~agree) | (st_r.s2 & agree);
      // Answer is a one-cycle pulse
      st_nxt.respond = 1'b0;
      st_nxt.use_lowest = i_lowest_supported & st_r.filt[`SYN_LOWEST];
      st_nxt.conflict = st_r.filt[`SYN_LOW] & st_r.filt[`SYN_LOWEST];
      case (st_r.state)
         ST_OFF: begin
            // Counters, ready flags, SPI mode and enhancements cleared while unpowered
            st_nxt.timer = '0;
            st_nxt.clk_cnt = `CLK_CNT_RESET;
            st_nxt.ready = 1'b0;
            st_nxt.phy_ready = 1'b0;
            st_nxt.spi = 1'b0;
            st_nxt.cq = 1'b0;
            st_nxt.cache = 1'b0;
            st_nxt.maint = 1'b0;
            if (supply_good) begin
               st_nxt.state = ST_PREP;
            end
         end
         ST_PREP: begin
            // Timer runs from supply good
            st_nxt.timer = st_r.timer + TW'(1);
            if (bus_clk_rise && !i_lane_mode && st_r.clk_cnt != `PREP_BUS_CLOCKS) begin
               st_nxt.clk_cnt = st_r.clk_cnt + 7'h01;
            end
            if (!supply_good) begin
               st_nxt.state = ST_OFF;
            end else if (timer_done || (!i_lane_mode && st_r.clk_cnt == `PREP_BUS_CLOCKS)) begin
               st_nxt.state = ST_IDLE;
               st_nxt.ready = !i_lane_mode;
               st_nxt.phy_ready = i_lane_mode;
            end
         end
         ST_IDLE: begin
            // Supply loss is a power cycle
            if (!supply_good) begin
               st_nxt.state = ST_OFF;
               st_nxt.ready = 1'b0;
               st_nxt.phy_ready = 1'b0;
            end else begin
               if (i_cmd0_rx && st_r.ready && !st_r.spi && !st_r.filt[`SYN_CS_N]) begin
                  st_nxt.spi = 1'b1;
               end
               if (i_cmd0_rx && st_r.ready && (st_r.spi || !st_r.filt[`SYN_CS_N])) begin
                  st_nxt.respond = 1'b1;
               end
               if (i_enable_cmd_queuing) begin
                  st_nxt.cq = 1'b1;
               end
               if (i_enable_cache) begin
                  st_nxt.cache = 1'b1;
               end
               if (i_enable_self_maint) begin
                  st_nxt.maint = 1'b1;
               end
               if (i_power_off_notify) begin
                  st_nxt.cq = 1'b0;
                  st_nxt.cache = 1'b0;
                  st_nxt.maint = 1'b0;
               end
            end
         end
         default: begin
            st_nxt.state = ST_OFF;
         end
      endcase
   end

   // Synchronous reset clears all state
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         st_r <= '{
            state: ST_OFF,
            timer: '0,
            clk_cnt: `CLK_CNT_RESET,
            s1: `SYN_RESET,
            s2: `SYN_RESET,
            s3: `SYN_RESET,
            filt: `SYN_RESET,
            default: 1'b0
         };
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_state = st_r.state;
   assign o_idle = (st_r.state == ST_IDLE);
   assign o_ready_for_cmd = st_r.ready;
   assign o_phy_init_ready = st_r.phy_ready;
   assign o_spi_mode = st_r.spi;
   assign o_cmd0_respond = st_r.respond;
   assign o_use_lowest_supply = st_r.use_lowest & !st_r.conflict;
   assign o_supply_conflict = st_r.conflict;
   assign o_cmd_queuing_en = st_r.cq;
   assign o_cache_en = st_r.cache;
   assign o_self_maint_en = st_r.maint;
endmodule : card_power_up_sequencer
`default_nettype wire

// ===== card_seq_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module card_seq_assertions
   import card_power_pkg::*;
#(parameter int READY_CYCLES = 100000) (
   input wire logic i_ref_clk, i_reset_n, i_main_supply_ok, i_lane_mode, i_cmd0_rx, i_power_off_notify,
   input wire logic o_idle, o_ready_for_cmd, o_phy_init_ready, o_spi_mode, o_cmd0_respond,
   input wire logic o_use_lowest_supply, o_supply_conflict, o_cmd_queuing_en, o_cache_en, o_self_maint_en,
   input wire card_state_t o_state
);
   int prep_n_r;
   always_ff @(posedge i_ref_clk) prep_n_r <= (o_state == ST_PREP) ? prep_n_r + 1 : 0;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   property p_idle; o_idle == (o_state == ST_IDLE); endproperty
   a_idle: assert property (p_idle) else $error("idle flag wrong");
   property p_rdy; $rose(o_ready_for_cmd) |-> o_state == ST_IDLE && !i_lane_mode; endproperty
   a_rdy: assert property (p_rdy) else $error("ready out of place");
   property p_phy; $rose(o_phy_init_ready) |-> o_state == ST_IDLE && i_lane_mode; endproperty
   a_phy: assert property (p_phy) else $error("phy ready out of place");
   property p_bound; prep_n_r <= READY_CYCLES; endproperty
   a_bound: assert property (p_bound) else $error("preparation too long");
   property p_spi; $rose(o_spi_mode) |-> o_cmd0_respond; endproperty
   a_spi: assert property (p_spi) else $error("spi without answer");
   property p_rsp; o_cmd0_respond |-> $past(i_cmd0_rx); endproperty
   a_rsp: assert property (p_rsp) else $error("answer without command");
   property p_cfl; o_supply_conflict |-> !o_use_lowest_supply; endproperty
   a_cfl: assert property (p_cfl) else $error("lowest used in conflict");
   property p_pon; o_state == ST_IDLE && i_power_off_notify |=> !(o_cmd_queuing_en || o_cache_en || o_self_maint_en);
   endproperty
   a_pon: assert property (p_pon) else $error("enhancement left on");
   property p_drop; $fell(i_main_supply_ok) |-> ##[1:8] o_state == ST_OFF; endproperty
   a_drop: assert property (p_drop) else $error("no return to off");
endmodule : card_seq_assertions
bind card_power_up_sequencer card_seq_assertions #(.READY_CYCLES(READY_CYCLES)) chk_i (.i_ref_clk, .i_reset_n,
   .i_main_supply_ok, .i_lane_mode, .i_cmd0_rx, .i_power_off_notify, .o_idle, .o_ready_for_cmd, .o_phy_init_ready,
   .o_spi_mode, .o_cmd0_respond, .o_use_lowest_supply, .o_supply_conflict, .o_cmd_queuing_en, .o_cache_en,
   .o_self_maint_en, .o_state);
`default_nettype wire

// ===== card_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module card_host_model #(
   parameter int N_CLKS = 74,
   // link clock half period in ns
   parameter int HALF_NS = 80
) (
   input wire logic i_start,
   input wire logic i_sel_n,
   output logic o_bus_clk,
   output logic o_cmd_line,
   output logic o_cs_n,
   output logic o_init_done
);
   logic init_r;
   assign o_cmd_line = 1'b1;
   assign o_cs_n = init_r | i_sel_n;
   // initial clocks after settle, then done
   initial begin
      init_r = 1'b0;
      o_init_done = 1'b0;
      o_bus_clk = 1'b0;
      forever begin
         @(posedge i_start);
         init_r = 1'b1;
         o_init_done = 1'b0;
         repeat (N_CLKS) begin
            #(HALF_NS) o_bus_clk = 1'b1;
            #(HALF_NS) o_bus_clk = 1'b0;
         end
         init_r = 1'b0;
         o_init_done = 1'b1;
      end
   end
endmodule : card_host_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import card_power_pkg::*;
   localparam int RC = 3000;
   logic i_ref_clk = 0, i_reset_n = 0, main = 0, low = 0, lowest = 0, lane = 0, lsup = 0;
   logic cmd0 = 0, eq = 0, ec = 0, es = 0, pon = 0, start = 0, sel_n = 1;
   logic idle, rdy, phy, spi, rsp, use_lo, cfl, q_en, c_en, m_en;
   wire bus_clk, cmd_line, cs_n, done;
   card_state_t state;
   int n_errors = 0, samples_checked = 0, n;
   always #5 i_ref_clk = ~i_ref_clk;
   card_host_model card_host_model_i (.i_start(start), .i_sel_n(sel_n), .o_bus_clk(bus_clk),
      .o_cmd_line(cmd_line), .o_cs_n(cs_n), .o_init_done(done));
   card_power_up_sequencer #(.READY_CYCLES(RC)) card_power_up_sequencer_i (.i_ref_clk, .i_reset_n,
      .i_main_supply_ok(main), .i_low_voltage_supply_ok(low), .i_lowest_voltage_supply_ok(lowest),
      .i_bus_clk(bus_clk), .i_cmd_line(cmd_line), .i_cs_n(cs_n), .i_lane_mode(lane), .i_lowest_supported(lsup),
      .i_cmd0_rx(cmd0), .i_enable_cmd_queuing(eq), .i_enable_cache(ec), .i_enable_self_maint(es),
      .i_power_off_notify(pon), .o_state(state), .o_idle(idle), .o_ready_for_cmd(rdy), .o_phy_init_ready(phy),
      .o_spi_mode(spi), .o_cmd0_respond(rsp), .o_use_lowest_supply(use_lo), .o_supply_conflict(cfl),
      .o_cmd_queuing_en(q_en), .o_cache_en(c_en), .o_self_maint_en(m_en));
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %0h seen %0h", s, e, g);
      end
   endtask : chk
   task test_done;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : test_done
   task cyc(input int k);
      repeat (k) @(negedge i_ref_clk);
   endtask : cyc
   task lim;
      if (n >= 9000) begin
         n_errors++;
         test_done;
      end
   endtask : lim
   task t_serial;
      main = 1;
      cyc(20);
      start = 1;
      for (n = 0; n < 9000 && rdy !== 1'b1; n++) cyc(1);
      lim;
      chk("ready_time", 1, n > 1150 && n < RC);
      chk("state", ST_IDLE, state);
      chk("idle", 1, idle);
      chk("phy", 0, phy);
      start = 0;
   endtask : t_serial
   task t_mode;
      for (n = 0; n < 9000 && done !== 1'b1; n++) cyc(1);
      lim;
      cmd0 = 1;
      cyc(1);
      cmd0 = 0;
      chk("rsp_native", 0, rsp);
      chk("spi_native", 0, spi);
      sel_n = 0;
      cyc(5);
      cmd0 = 1;
      cyc(1);
      cmd0 = 0;
      chk("rsp_spi", 1, rsp);
      chk("spi", 1, spi);
      cyc(1);
      chk("rsp_pulse", 0, rsp);
      sel_n = 1;
   endtask : t_mode
   task t_enh;
      {eq, ec, es} = 3'h7;
      cyc(1);
      {eq, ec, es} = 3'h0;
      chk("enh_on", 3'h7, {q_en, c_en, m_en});
      pon = 1;
      ec = 1;
      cyc(1);
      {pon, ec} = 2'h0;
      chk("enh_off", 3'h0, {q_en, c_en, m_en});
   endtask : t_enh
   task t_lane;
      main = 0;
      cyc(8);
      chk("off_state", ST_OFF, state);
      chk("off_spi", 0, spi);
      cyc(100);
      {lane, lsup, main} = 3'h7;
      cyc(30);
      lowest = 1;
      for (n = 0; n < 9000 && phy !== 1'b1; n++) cyc(1);
      lim;
      chk("phy_time", 1, n >= RC && n <= RC + 8);
      chk("lane_rdy", 0, rdy);
      chk("lowest", 2'h1, {cfl, use_lo});
      low = 1;
      cyc(8);
      chk("conflict", 2'h2, {cfl, use_lo});
   endtask : t_lane
   initial begin
      cyc(6);
      i_reset_n = 1;
      t_serial;
      t_mode;
      t_enh;
      t_lane;
      test_done;
   end
endmodule : testbench
`default_nettype wire
